/* File: verilog/rsm_top.sv */
// Purpose: reset source monitor and system reset generator
// Assumes: nrst is the power-on reset; pins are asynchronous
// Notes: system reset is held a fixed time after its cause ends
//
// Behaviour
// - bit 7 of supply_monitor_control switches the supply monitor off (0) or on (1).
// - the supply monitor resets the system only when enabled and selected in reset_source_flags.
// - power-on sets the monitor enable to 1; other resets leave it as it was.
// - bit 6 of supply_monitor_control reads the monitor output, 1 when above threshold.
// - bits 5:0 of supply_monitor_control are unused and ignore writes.
// - a low level on the external reset pin holds the system in reset.
// - leaving a pin reset sets pin_reset_flag in bit 0 of reset_source_flags.
// - the missing-clock detector is a retriggered one-shot that resets on a stalled clock.
// - bit 2 of reset_source_flags reads 1 after a clock-loss reset with no pin reset in the same hold, and 0 otherwise.
// - writing 1 or 0 to bit 2 of reset_source_flags enables or disables the detector.
// - a clock-loss reset never drives the external reset pin.
`timescale 1ns/1ps
module rsm_top
  import rsm_pkg::*;
#(
  parameter int TIMEOUT = CLK_TIMEOUT_CYC,
  parameter int HOLD = HOLD_CYC
) (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins and analog
  input wire logic rst_pin_n,
  input wire logic supply_above,
  input wire logic sys_clk_mon,
  output logic supply_monitor_enable,
  // system reset and interrupt
  output logic sys_rst_n,
  output logic irq
);

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD - 1);

  typedef struct packed {
    rsm_state_e st;
    logic [HOLD_W-1:0] hold;
    logic [EV_N-1:0] pend;
    logic sup_en;
    logic sup_sel;
    logic clk_en;
    logic pin_flag;
    logic clk_flag;
    logic [EV_N-1:0] stat;
    logic [EV_N-1:0] mask;
    logic [7:0] rdata;
  } rsm_top_s;

  rsm_top_s r_q;
  rsm_top_s r_d;

  logic pin_n_s;
  logic above_s;
  logic mon_s;
  logic clk_lost;
  logic [EV_N-1:0] cause;
  logic [EV_N-1:0] set_ev;
  logic [7:0] rd_val;

  rsm_sync #(
    .W(3),
    .RST_VAL(3'h3)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d({sys_clk_mon, supply_above, rst_pin_n}),
    .q({mon_s, above_s, pin_n_s})
  );

  rsm_clk_watch #(
    .TIMEOUT(TIMEOUT),
    .CW(CLK_CNT_W)
  ) u_watch (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .en(r_q.clk_en),
    .mon_s(mon_s),
    .timeout(clk_lost)
  );

  always_comb begin
    cause = '0;
    cause[EV_PIN] = !pin_n_s;
    cause[EV_SUP] = r_q.sup_en && r_q.sup_sel && !above_s;
    cause[EV_CLK] = clk_lost;
  end

  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      ADDR_RST_SRC: begin
        rd_val[RS_PIN_BIT] = r_q.pin_flag;
        rd_val[RS_SUP_SEL_BIT] = r_q.sup_sel;
        rd_val[RS_CLK_BIT] = r_q.clk_flag;
      end
      ADDR_SUP_CTL: begin
        rd_val[SC_EN_BIT] = r_q.sup_en;
        rd_val[SC_LVL_BIT] = above_s;
      end
      ADDR_EVT_STAT: begin
        rd_val[EV_N-1:0] = r_q.stat;
      end
      ADDR_EVT_MASK: begin
        rd_val[EV_N-1:0] = r_q.mask;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  always_comb begin
    r_d = r_q;
    set_ev = '0;
    r_d.rdata = reg_rd ? rd_val : 8'h00;

    case (r_q.st)
      RSM_RUN: begin
        if (|cause) begin
          r_d.st = RSM_HOLD;
          r_d.pend = cause;
          r_d.hold = '0;
        end
      end
      RSM_HOLD: begin
        r_d.pend = r_q.pend | cause;
        if (|cause) begin
          r_d.hold = '0;
        end else if (r_q.hold == HOLD_LAST) begin
          r_d.st = RSM_RUN;
          r_d.pin_flag = r_q.pend[EV_PIN];
          r_d.clk_flag = r_q.pend[EV_CLK] && !r_q.pend[EV_PIN];
          set_ev = r_q.pend;
        end else begin
          r_d.hold = r_q.hold + 1'b1;
        end
      end
      default: begin
        r_d.st = RSM_RUN;
      end
    endcase

    if (reg_wr) begin
      case (reg_addr)
        ADDR_RST_SRC: begin
          r_d.sup_sel = reg_wdata[RS_SUP_SEL_BIT];
          r_d.clk_en = reg_wdata[RS_CLK_BIT];
        end
        ADDR_SUP_CTL: begin
          r_d.sup_en = reg_wdata[SC_EN_BIT];
        end
        ADDR_EVT_STAT: begin
          r_d.stat = r_q.stat & ~reg_wdata[EV_N-1:0];
        end
        ADDR_EVT_MASK: begin
          r_d.mask = reg_wdata[EV_N-1:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over clear
    r_d.stat = r_d.stat | set_ev;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_q.st <= RSM_RUN;
      r_q.hold <= '0;
      r_q.pend <= '0;
      r_q.sup_en <= RST_SUP_EN;
      r_q.sup_sel <= RST_SUP_SEL;
      r_q.clk_en <= RST_CLK_EN;
      r_q.pin_flag <= 1'b0;
      r_q.clk_flag <= 1'b0;
      r_q.stat <= RST_EVT;
      r_q.mask <= RST_EVT;
      r_q.rdata <= RST_RDATA;
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign supply_monitor_enable = r_q.sup_en;
  assign sys_rst_n = (r_q.st == RSM_RUN);
  assign irq = |(r_q.stat & r_q.mask);

endmodule : rsm_top

/* File: verilog/rsm_pkg.sv */
// Purpose: shared constants for the reset source monitor
// Assumes: 10 MHz ref_clk, 8-bit register port
// Notes: register offsets and reset values live here
package rsm_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 100;

  // register offsets
  localparam logic [7:0] ADDR_RST_SRC = 8'hef;
  localparam logic [7:0] ADDR_SUP_CTL = 8'hff;
  localparam logic [7:0] ADDR_EVT_STAT = 8'h40;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h41;

  // reset_source_flags fields
  localparam int RS_PIN_BIT = 0;
  localparam int RS_SUP_SEL_BIT = 1;
  localparam int RS_CLK_BIT = 2;

  // supply_monitor_control fields
  localparam int SC_EN_BIT = 7;
  localparam int SC_LVL_BIT = 6;

  // event bits in status and mask
  localparam int EV_PIN = 0;
  localparam int EV_SUP = 1;
  localparam int EV_CLK = 2;
  localparam int EV_N = 3;

  // values after power-on
  localparam logic RST_SUP_EN = 1'b1;
  localparam logic RST_SUP_SEL = 1'b0;
  localparam logic RST_CLK_EN = 1'b0;
  localparam logic [EV_N-1:0] RST_EVT = 3'h0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // timing
  localparam int CLK_TIMEOUT_NS = 100000;
  localparam int CLK_TIMEOUT_CYC = CLK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int HOLD_NS = 1000;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 8;
  localparam int CLK_CNT_W = 16;

  // sequencer states, gray along run -> hold
  typedef enum logic [0:0] {
    RSM_RUN = 1'b0,
    RSM_HOLD = 1'b1
  } rsm_state_e;

endpackage : rsm_pkg

/* File: verilog/rsm_sync.sv */
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: inputs are static levels relative to ref_clk
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module rsm_sync
  import rsm_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsm_sync_s;

  rsm_sync_s r_q;
  rsm_sync_s r_d;

  always_comb begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_q <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;

endmodule : rsm_sync

/* File: verilog/rsm_clk_watch.sv */
// Purpose: missing-clock one-shot on a watched clock level
// Assumes: mon_s is already synchronised to ref_clk
// Notes: timeout stays high until an edge returns or watch is off
`timescale 1ns/1ps
module rsm_clk_watch
  import rsm_pkg::*;
#(
  parameter int TIMEOUT = CLK_TIMEOUT_CYC,
  parameter int CW = CLK_CNT_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control and watched level
  input wire logic en,
  input wire logic mon_s,
  // result
  output logic timeout
);

  localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

  typedef struct packed {
    logic prev;
    logic [CW-1:0] cnt;
    logic to;
  } rsm_watch_s;

  rsm_watch_s r_q;
  rsm_watch_s r_d;

  always_comb begin
    r_d = r_q;
    r_d.prev = mon_s;
    if (!en) begin
      r_d.cnt = '0;
      r_d.to = 1'b0;
    end else if (mon_s != r_q.prev) begin
      r_d.cnt = '0;
      r_d.to = 1'b0;
    end else if (r_q.cnt == LAST) begin
      r_d.to = 1'b1;
    end else begin
      r_d.cnt = r_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r_q <= '{prev: 1'b0, cnt: '0, to: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign timeout = r_q.to;

endmodule : rsm_clk_watch

/* File: dv/rsm_checker.sv */
// Purpose: port checks of rsm_top
// Assumes: one reset cause at a time
// Notes: bound below
`timescale 1ns/1ps
module rsm_checker
  import rsm_pkg::*;
(
  // watched ports
  input logic ref_clk,
  input logic nrst,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic rst_pin_n,
  input logic supply_above,
  input logic supply_monitor_enable,
  input logic sys_rst_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_pin; !rst_pin_n [*3]; endsequence
  sequence s_rdc; reg_rd && reg_addr == ADDR_SUP_CTL; endsequence
  property p_pin; s_pin |=> !sys_rst_n; endproperty
  a_pin: assert property (p_pin) else $error("no pin reset");
  property p_hold; !sys_rst_n && !rst_pin_n |=> !sys_rst_n; endproperty
  a_hold: assert property (p_hold) else $error("early exit");
  property p_sync; $fell(rst_pin_n) && sys_rst_n |=> sys_rst_n [*2]; endproperty
  a_sync: assert property (p_sync) else $error("pin unsynced");
  property p_wr; reg_wr && reg_addr == ADDR_SUP_CTL |=> supply_monitor_enable == $past(reg_wdata[7]); endproperty
  a_wr: assert property (p_wr) else $error("enable not written");
  property p_por; $rose(nrst) |-> supply_monitor_enable; endproperty
  a_por: assert property (p_por) else $error("enable off");
  property p_keep; !sys_rst_n && !reg_wr |=> $stable(supply_monitor_enable); endproperty
  a_keep: assert property (p_keep) else $error("enable lost");
  property p_lvl; $stable(supply_above) [*4] ##0 s_rdc |=> reg_rdata[6] == $past(supply_above); endproperty
  a_lvl: assert property (p_lvl) else $error("level wrong");
  property p_unused; s_rdc |=> reg_rdata[5:0] == 6'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused set");
endmodule : rsm_checker
bind rsm_top rsm_checker u_chk (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .rst_pin_n, .supply_above, .supply_monitor_enable, .sys_rst_n);

/* File: dv/rsm_pin_drv.sv */
// Purpose: external circuit on the reset pin
// Assumes: pin has a pull-up
// Notes: low time given per request
`timescale 1ns/1ps
module rsm_pin_drv (
  // request
  input logic ref_clk,
  input logic go,
  input logic [7:0] len,
  // pin
  output logic rst_pin_n
);
  initial rst_pin_n = 1'h1;
  always @(posedge ref_clk) begin
    if (go) begin
      rst_pin_n <= 1'h0;
      repeat (len) @(posedge ref_clk);
      rst_pin_n <= 1'h1;
    end
  end
endmodule : rsm_pin_drv

/* File: dv/reset_source_monitor_tb.sv */
// Purpose: register-level test of rsm_top
// Assumes: TIMEOUT 20, HOLD 3
// Notes: pin driven by rsm_pin_drv
`timescale 1ns/1ps
module reset_source_monitor_tb
  import rsm_pkg::*;
;
  localparam int TO = 20;
  logic ref_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0, run = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, len = 8'h04, reg_rdata;
  logic supply_above = 1'h1, sys_clk_mon = 1'h0, rst_pin_n, supply_monitor_enable, sys_rst_n, irq;
  int failures = 0, cmp_count = 0, n = 0;
  rsm_top #(.TIMEOUT(TO), .HOLD(3)) u_dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rst_pin_n, .supply_above, .sys_clk_mon, .supply_monitor_enable, .sys_rst_n, .irq);
  rsm_pin_drv u_pin (.ref_clk, .go, .len, .rst_pin_n);
  initial begin
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (run) sys_clk_mon <= ~sys_clk_mon;
  end
  task automatic ck(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : ck
  task automatic cb(input string nm, input logic e, input logic s);
    ck(nm, {7'h00, e}, {7'h00, s});
  endtask : cb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    ck("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic wt(input logic v);
    n = 0;
    while (sys_rst_n !== v && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    cb("sys_rst_n", v, sys_rst_n);
    if (sys_rst_n !== v) print_verdict();
  endtask : wt
  task automatic idle(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
    cb("sys_rst_n", 1'h1, sys_rst_n);
  endtask : idle
  task automatic iq(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    cb("irq", e, irq);
  endtask : iq
  task automatic pin(input logic [7:0] k);
    @(posedge ref_clk);
    go <= 1'h1;
    len <= k;
    @(posedge ref_clk);
    go <= 1'h0;
    wt(1'h0);
    wt(1'h1);
  endtask : pin
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(ADDR_SUP_CTL, 8'hc0);
    rd(ADDR_RST_SRC, 8'h00);
    rd(8'h00, 8'h00);
    wr(ADDR_SUP_CTL, 8'h3f);
    rd(ADDR_SUP_CTL, 8'h40);
    wr(ADDR_RST_SRC, 8'h02);
    @(posedge ref_clk);
    supply_above <= 1'h0;
    idle(8);
    rd(ADDR_SUP_CTL, 8'h00);
    wr(ADDR_SUP_CTL, 8'h80);
    wt(1'h0);
    @(posedge ref_clk);
    supply_above <= 1'h1;
    wt(1'h1);
    rd(ADDR_EVT_STAT, 8'h02);
    wr(ADDR_EVT_STAT, 8'h02);
    wr(ADDR_RST_SRC, 8'h00);
    wr(ADDR_EVT_MASK, 8'h07);
    wr(ADDR_SUP_CTL, 8'h00);
    pin(8'h04);
    iq(1'h1);
    rd(ADDR_RST_SRC, 8'h01);
    rd(ADDR_SUP_CTL, 8'h40);
    wr(ADDR_EVT_MASK, 8'h00);
    iq(1'h0);
    wr(ADDR_EVT_MASK, 8'h07);
    iq(1'h1);
    wr(ADDR_EVT_STAT, 8'h01);
    run <= 1'h1;
    iq(1'h0);
    wr(ADDR_RST_SRC, 8'h04);
    idle(3 * TO);
    @(posedge ref_clk);
    run <= 1'h0;
    wt(1'h0);
    cb("delay", 1'h1, n >= TO);
    cb("rst_pin_n", 1'h1, rst_pin_n);
    @(posedge ref_clk);
    run <= 1'h1;
    wt(1'h1);
    rd(ADDR_RST_SRC, 8'h04);
    pin(8'h0c);
    rd(ADDR_RST_SRC, 8'h01);
    wr(ADDR_RST_SRC, 8'h00);
    run <= 1'h0;
    idle(3 * TO);
    wr(ADDR_SUP_CTL, 8'h80);
    idle(8);
    cb("supply_monitor_enable", 1'h1, supply_monitor_enable);
    wr(ADDR_RST_SRC, 8'h02);
    idle(8);
    wr(ADDR_SUP_CTL, 8'h00);
    nrst <= 1'h0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    rd(ADDR_SUP_CTL, 8'hc0);
    rd(ADDR_RST_SRC, 8'h00);
    print_verdict();
  end
endmodule : reset_source_monitor_tb
